// *** hdl/sfc_top.sv ***
// Control core: serial command decoder, configuration, conversion sequencing.
// Assumes conversion result arrives from the converter on the reference clock.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module sfc_top #(
  parameter int CONV_CYCLES = sfc_pkg::CONV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic por_n,
  input wire logic chip_enable_n,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  input wire logic pump_on_pin,
  output logic pump_run,
  input wire logic [3:0] aux_inputs,
  output logic [3:0] aux_outputs,
  output logic input_select_bit_high,
  output logic input_select_bit_mid,
  output logic input_select_bit_low,
  output logic attenuator_switch,
  output logic junction_excitation_en,
  output logic conversion_done_flag,
  output logic conv_run,
  input wire logic [sfc_pkg::RESULT_W-1:0] conv_result,
  output logic clock_replica_out,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic irq
);
  // Counter must see at least one decrement before the end test
  if (CONV_CYCLES < 2) begin : g_bad_conv
    $error("CONV_CYCLES must be at least 2");
  end

  typedef enum logic [1:0] {SFC_CMD, SFC_WR_CFG, SFC_WR_AUX, SFC_READ} sfc_state_t;

  sfc_link_if link ();

  sfc_shifter u_shifter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .chip_enable_n(chip_enable_n),
    .shift_clock(shift_clock),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n),
    .link(link.shifter)
  );

  sfc_state_t state_reg;
  sfc_state_t state_next;
  logic [4:0] cfg_reg;
  logic [3:0] aux_out_reg;
  logic [1:0] zero_cnt_reg;
  logic [7:0] tx_byte_reg;
  logic tx_en_reg;
  logic [1:0] rd_left_reg;
  logic [sfc_pkg::RESULT_W-1:0] rd_sr_reg;
  logic [sfc_pkg::RESULT_W-1:0] result_reg;
  logic busy_reg;
  logic done_reg;
  logic [31:0] conv_cnt_reg;
  logic [sfc_pkg::EV_W-1:0] irq_status_reg;
  logic [sfc_pkg::EV_W-1:0] irq_mask_reg;
  logic [31:0] reg_rdata_reg;
  logic [1:0] pump_sync_reg;
  logic [3:0] aux_s1_reg;
  logic [3:0] aux_s2_reg;

  // Byte decode
  wire byte_in = link.rx_valid;
  wire [7:0] rx = link.rx_byte;
  wire [2:0] opcode = rx[7:5];
  wire zero_byte = byte_in & (rx == 8'h00);
  wire resync = zero_byte & (zero_cnt_reg == 2'(sfc_pkg::ZERO_BYTES_RESYNC - 1));
  wire cmd_byte = byte_in & (state_reg == SFC_CMD);
  wire cmd_start = cmd_byte & (opcode == sfc_pkg::OP_START);
  wire cmd_rd_stat = cmd_byte & (opcode == sfc_pkg::OP_RD_STATUS);
  wire cmd_rd_res = cmd_byte & (opcode == sfc_pkg::OP_RD_RESULT);
  wire cmd_rd_cfg = cmd_byte & (opcode == sfc_pkg::OP_RD_CFG);
  wire cmd_bad = cmd_byte & (opcode == 3'h7);
  wire cfg_byte_wr = byte_in & (state_reg == SFC_WR_CFG) & ~resync;
  wire aux_byte_wr = byte_in & (state_reg == SFC_WR_AUX) & ~resync;
  wire read_byte_done = byte_in & (state_reg == SFC_READ);

  // Register port decode
  wire sel_cfg = reg_addr == sfc_pkg::REG_CONFIG;
  wire sel_aux = reg_addr == sfc_pkg::REG_AUX;
  wire sel_ists = reg_addr == sfc_pkg::REG_IRQ_STATUS;
  wire sel_imsk = reg_addr == sfc_pkg::REG_IRQ_MASK;
  wire sel_ctl = reg_addr == sfc_pkg::REG_CONTROL;
  wire sel_res = reg_addr == sfc_pkg::REG_RESULT;
  wire reg_start = reg_we & sel_ctl & reg_wdata[0];
  wire start_conv = (cmd_start | reg_start) & ~busy_reg;
  wire conv_end = busy_reg & (conv_cnt_reg == 32'h1);

  wire [7:0] status_byte = {done_reg, busy_reg, 2'h0, aux_s2_reg}; // R7 R11
  wire [7:0] cfg_byte = {3'h0, cfg_reg};
  wire [sfc_pkg::EV_W-1:0] events = {cmd_bad, resync, conv_end};

  // Command sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SFC_CMD: begin
        if (byte_in) begin
          case (opcode)
            sfc_pkg::OP_WR_CFG: state_next = SFC_WR_CFG;
            sfc_pkg::OP_WR_AUX: state_next = SFC_WR_AUX;
            sfc_pkg::OP_RD_STATUS: state_next = SFC_READ;
            sfc_pkg::OP_RD_RESULT: state_next = SFC_READ;
            sfc_pkg::OP_RD_CFG: state_next = SFC_READ;
            default: state_next = SFC_CMD;
          endcase
        end
      end
      SFC_WR_CFG: if (byte_in) state_next = SFC_CMD;
      SFC_WR_AUX: if (byte_in) state_next = SFC_CMD;
      SFC_READ: if (byte_in && rd_left_reg == 2'h1) state_next = SFC_CMD;
      default: state_next = SFC_CMD;
    endcase
    if (resync) begin
      state_next = SFC_CMD; // R14
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SFC_CMD; // R5
      zero_cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (byte_in) begin
        zero_cnt_reg <= (zero_byte && !resync) ? zero_cnt_reg + 2'h1 : 2'h0; // R14
      end
    end
  end

  // Read sequencing: bytes queued for the next framed bytes, MSB first
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_en_reg <= 1'b0; // R5
      tx_byte_reg <= 8'h00;
      rd_left_reg <= 2'h0;
      rd_sr_reg <= '0;
    end else if (resync) begin
      tx_en_reg <= 1'b0;
      rd_left_reg <= 2'h0;
    end else if (cmd_rd_stat) begin
      tx_en_reg <= 1'b1; // R8
      tx_byte_reg <= status_byte;
      rd_left_reg <= 2'h1;
    end else if (cmd_rd_cfg) begin
      tx_en_reg <= 1'b1;
      tx_byte_reg <= cfg_byte;
      rd_left_reg <= 2'h1;
    end else if (cmd_rd_res) begin
      tx_en_reg <= 1'b1;
      tx_byte_reg <= result_reg[23:16];
      rd_sr_reg <= {result_reg[15:0], 8'h00};
      rd_left_reg <= 2'h3;
    end else if (read_byte_done) begin
      rd_left_reg <= rd_left_reg - 2'h1;
      tx_byte_reg <= rd_sr_reg[23:16];
      rd_sr_reg <= {rd_sr_reg[15:0], 8'h00};
      tx_en_reg <= (rd_left_reg != 2'h1); // R8
    end
  end

  assign link.tx_byte = tx_byte_reg;
  assign link.tx_en = tx_en_reg;

  // Configuration survives the reset pin; only power-on clears it
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      cfg_reg <= sfc_pkg::CFG_RESET;
      aux_out_reg <= sfc_pkg::AUX_OUT_RESET;
    end else begin
      if (cfg_byte_wr) begin
        cfg_reg <= rx[4:0]; // R18 R13
      end else if (reg_we && sel_cfg) begin
        cfg_reg <= reg_wdata[4:0];
      end
      if (aux_byte_wr) begin
        aux_out_reg <= rx[3:0]; // R16
      end else if (reg_we && sel_aux) begin
        aux_out_reg <= reg_wdata[3:0];
      end
    end
  end

  // Converter sequencing; reset aborts a running conversion
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 1'b0; // R13
      done_reg <= 1'b0;
      conv_cnt_reg <= 32'h0;
      result_reg <= '0;
    end else if (start_conv) begin
      busy_reg <= 1'b1;
      done_reg <= 1'b0; // R15
      conv_cnt_reg <= 32'(CONV_CYCLES);
    end else if (busy_reg) begin
      conv_cnt_reg <= conv_cnt_reg - 32'h1;
      if (conv_end) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1; // R6
        result_reg <= conv_result;
      end
    end
  end

  // Interrupts: a new event wins over a same-cycle clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~((reg_we && sel_ists) ?
                        reg_wdata[sfc_pkg::EV_W-1:0] : '0)) | events;
      if (reg_we && sel_imsk) begin
        irq_mask_reg <= reg_wdata[sfc_pkg::EV_W-1:0];
      end
    end
  end

  // Register read data, valid only the cycle after the strobe
  wire [31:0] rd_mux =
    sel_cfg ? {27'h0, cfg_reg} :
    sel_aux ? {24'h0, aux_s2_reg, aux_out_reg} :
    sel_ists ? {29'h0, irq_status_reg} :
    sel_imsk ? {29'h0, irq_mask_reg} :
    sel_ctl ? {30'h0, done_reg, busy_reg} :
    sel_res ? {8'h0, result_reg} : 32'h0;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_reg <= 32'h0;
    end else begin
      reg_rdata_reg <= reg_re ? rd_mux : 32'h0;
    end
  end

  // Pin inputs synchronised before use
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pump_sync_reg <= 2'h0;
      aux_s1_reg <= 4'h0;
      aux_s2_reg <= 4'h0;
    end else begin
      pump_sync_reg <= {pump_sync_reg[0], pump_on_pin};
      aux_s1_reg <= aux_inputs;
      aux_s2_reg <= aux_s1_reg;
    end
  end

  // Attenuator only meaningful on the four field inputs
  wire field_sel = ~cfg_reg[sfc_pkg::CFG_SEL_LSB + 2];

  assign pump_run = pump_sync_reg[1]; // R4
  assign aux_outputs = aux_out_reg; // R16
  assign input_select_bit_high = cfg_reg[sfc_pkg::CFG_SEL_LSB + 2]; // R1
  assign input_select_bit_mid = cfg_reg[sfc_pkg::CFG_SEL_LSB + 1]; // R1
  assign input_select_bit_low = cfg_reg[sfc_pkg::CFG_SEL_LSB]; // R1
  assign attenuator_switch = cfg_reg[sfc_pkg::CFG_ATT_BIT] & field_sel; // R2
  assign junction_excitation_en = cfg_reg[sfc_pkg::CFG_EXC_BIT]; // R3
  assign conversion_done_flag = done_reg; // R6 R15
  assign conv_run = busy_reg;
  assign clock_replica_out = ref_clk; // R12
  assign reg_rdata = reg_rdata_reg;
  assign irq = |(irq_status_reg & irq_mask_reg);
endmodule : sfc_top

// *** hdl/sfc_pkg.sv ***
// Constants for the serial control block of a four-channel measurement front end.
// Assumes one 25 MHz reference clock; serial pins are asynchronous to it.
// Behaviour
// [R1] Three-bit select routes four field inputs, ground, die temp, junction, reference.
// [R2] A control bit switches field inputs to the 4:1 attenuated configuration.
// [R3] A control bit switches off the junction sensor excitation.
// [R4] Charge pump runs only while the pump pin is at logic one.
// [R5] Reset low forces the serial interface into command state.
// [R6] Conversion-done pin high once the latest result is ready.
// [R7] Conversion-done also appears as a bit of the status byte.
// [R8] Serial output is released except while a read command executes.
// [R9] Controller frames every byte with chip enable.
// [R10] Controller supplies shift clock; device samples and shifts data with it.
// [R11] Four auxiliary input levels are readable over the serial port.
// [R12] A buffered copy of the oscillator clock leaves on its own pin.
// [R13] Reset aborts conversion and converter control but keeps configuration.
// [R14] Four consecutive zero bytes return the port to command state.
// [R15] Conversion-done pin stays low for the whole conversion.
// [R16] Four auxiliary outputs take levels written over the serial port.
// [R17] Input sampled on rising shift clock, output changes on falling, MSB first.
// [R18] Select, attenuator and excitation settings live in written configuration registers.
package sfc_pkg;
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int CONV_TIME_US = 1000;
  localparam int CONV_CYCLES = CONV_TIME_US * (CLK_FREQ_HZ / 1000000);
  localparam int RESULT_W = 24;
  localparam int ZERO_BYTES_RESYNC = 4;

  // Serial command opcodes in bits 7:5 of a command byte
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_WR_CFG = 3'h1;
  localparam logic [2:0] OP_WR_AUX = 3'h2;
  localparam logic [2:0] OP_START = 3'h3;
  localparam logic [2:0] OP_RD_STATUS = 3'h4;
  localparam logic [2:0] OP_RD_RESULT = 3'h5;
  localparam logic [2:0] OP_RD_CFG = 3'h6;

  // Configuration byte fields
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_ATT_BIT = 3;
  localparam int CFG_EXC_BIT = 4;
  localparam logic [4:0] CFG_RESET = 5'h10;
  localparam logic [3:0] AUX_OUT_RESET = 4'h0;

  // Status byte fields
  localparam int STB_DONE_BIT = 7;
  localparam int STB_BUSY_BIT = 6;

  // Register port map
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_AUX = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_CONTROL = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;

  // Interrupt event bits
  localparam int EV_DONE = 0;
  localparam int EV_RESYNC = 1;
  localparam int EV_BADCMD = 2;
  localparam int EV_W = 3;
endpackage : sfc_pkg

// *** hdl/sfc_link_if.sv ***
// Byte-level carrier between the serial shifter and the control core.
// Assumes both ends run on the reference clock.
`timescale 1ns/10ps
interface sfc_link_if;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic frame_start;
  logic [7:0] tx_byte;
  logic tx_en;
  modport shifter (output rx_byte, output rx_valid, output frame_start,
                   input tx_byte, input tx_en);
  modport core (input rx_byte, input rx_valid, input frame_start,
                output tx_byte, output tx_en);
endinterface : sfc_link_if

// *** hdl/sfc_shifter.sv ***
// Serial byte shifter: samples pins, frames bytes by chip enable.
// Assumes shift clock well below a quarter of the reference clock.
`timescale 1ns/10ps
module sfc_shifter (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic chip_enable_n,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  sfc_link_if.shifter link
);
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic sck_d_reg;
  logic ce_d_reg;
  logic [7:0] rx_sr_reg;
  logic [7:0] tx_sr_reg;
  logic [2:0] bit_cnt_reg;
  logic rx_valid_reg;
  logic frame_start_reg;

  wire sck_s = s2_reg[0];
  wire ce_act = ~s2_reg[1];
  wire di_s = s2_reg[2];
  wire sck_rise = sck_s & ~sck_d_reg & ce_act;
  wire sck_fall = ~sck_s & sck_d_reg & ce_act;
  wire ce_start = ce_act & ~ce_d_reg;

  // Two stages before any logic sees the pins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 3'h2;
      s2_reg <= 3'h2;
      sck_d_reg <= 1'b0;
      ce_d_reg <= 1'b0;
    end else begin
      s1_reg <= {serial_in, chip_enable_n, shift_clock};
      s2_reg <= s1_reg;
      sck_d_reg <= sck_s;
      ce_d_reg <= ce_act;
    end
  end

  // Partial bytes are dropped when chip enable leaves early
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sr_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!ce_act) begin
        bit_cnt_reg <= 3'h0; // R9
      end else if (sck_rise) begin
        rx_sr_reg <= {rx_sr_reg[6:0], di_s}; // R10 R17
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        rx_valid_reg <= (bit_cnt_reg == 3'h7);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sr_reg <= 8'h00;
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
      frame_start_reg <= 1'b0;
    end else begin
      frame_start_reg <= ce_start;
      serial_out_oe_n <= ~(ce_act & link.tx_en); // R8
      if (ce_start) begin
        tx_sr_reg <= link.tx_byte;
        serial_out <= link.tx_byte[7]; // R17
      end else if (sck_fall) begin
        tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
        serial_out <= tx_sr_reg[6]; // R10
      end
    end
  end

  assign link.rx_byte = rx_sr_reg;
  assign link.rx_valid = rx_valid_reg;
  assign link.frame_start = frame_start_reg;
endmodule : sfc_shifter

// *** sim/sfc_top_asserts.sv ***
// Port checker for the serial control block, bound onto sfc_top.
// Assumes a single reference clock domain and the active-low reset pin.
`timescale 1ns/10ps
module sfc_top_asserts #(
  parameter int CONV_CYCLES = sfc_pkg::CONV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic por_n,
  input wire logic chip_enable_n,
  input wire logic serial_out_oe_n,
  input wire logic pump_on_pin,
  input wire logic pump_run,
  input wire logic [3:0] aux_outputs,
  input wire logic input_select_bit_high,
  input wire logic input_select_bit_mid,
  input wire logic input_select_bit_low,
  input wire logic attenuator_switch,
  input wire logic junction_excitation_en,
  input wire logic conversion_done_flag,
  input wire logic conv_run,
  input wire logic reg_we
);
  logic [1:0] up_cnt_reg;
  logic [15:0] run_cnt_reg;
  wire [7:0] cfg_w = {aux_outputs, input_select_bit_high, input_select_bit_mid,
                      input_select_bit_low, junction_excitation_en};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Up counter masks the pump pipeline still filling after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_cnt_reg <= 2'h0;
      run_cnt_reg <= 16'h0;
    end else begin
      up_cnt_reg <= (up_cnt_reg == 2'h3) ? up_cnt_reg : up_cnt_reg + 2'h1;
      run_cnt_reg <= conv_run ? run_cnt_reg + 16'h1 : 16'h0;
    end
  end
  sequence s_quiet;
    (chip_enable_n && !reg_we) [*8];
  endsequence
  sequence s_conv_end;
    $fell(conv_run);
  endsequence
  a_oe_needs_ce: assert property (chip_enable_n [*4] |-> serial_out_oe_n)
    else $error("data out driven outside frame");
  a_atten_field: assert property (attenuator_switch |-> !input_select_bit_high)
    else $error("attenuator on non-field source");
  a_pump_follow: assert property (up_cnt_reg == 2'h3 |-> pump_run == $past(pump_on_pin, 2))
    else $error("pump run not following pin");
  a_done_low_busy: assert property (conv_run |-> !conversion_done_flag)
    else $error("done high while converting");
  a_conv_length: assert property (s_conv_end |->
    conversion_done_flag && run_cnt_reg == 16'(CONV_CYCLES))
    else $error("conversion length or done wrong");
  a_done_at_end: assert property ($rose(conversion_done_flag) |-> $past(conv_run))
    else $error("done rose without conversion");
  a_reset_quiet: assert property ($rose(reset_n) |->
    !conv_run && !conversion_done_flag && serial_out_oe_n)
    else $error("outputs active in reset");
  a_cfg_hold: assert property (s_quiet |=> !por_n || $stable(cfg_w))
    else $error("config changed without write");
endmodule : sfc_top_asserts
bind sfc_top sfc_top_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_sfc_top_asserts (.ref_clk,
  .reset_n, .por_n, .chip_enable_n, .serial_out_oe_n, .pump_on_pin, .pump_run,
  .aux_outputs, .input_select_bit_high, .input_select_bit_mid, .input_select_bit_low,
  .attenuator_switch, .junction_excitation_en, .conversion_done_flag, .conv_run, .reg_we);

// *** sim/sfc_ctl_model.sv ***
// Controller model: frames bytes with chip enable and makes the shift clock.
// Assumes the device samples on rising and shifts out on falling shift edges.
`timescale 1ns/10ps
module sfc_ctl_model #(
  parameter int HALF = 4
) (
  input wire logic ref_clk,
  output logic chip_enable_n,
  output logic shift_clock,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  logic last_reg = 1'b0;
  // Released line shows the inverse, so stale data never passes
  wire sdo_w = serial_out_oe_n ? ~last_reg : serial_out;
  always @(posedge ref_clk) begin
    if (!serial_out_oe_n) last_reg <= serial_out;
  end
  initial begin
    chip_enable_n = 1'b1;
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic drove);
    drove = 1'b0;
    @(posedge ref_clk);
    chip_enable_n <= 1'b0;
    repeat (HALF) @(posedge ref_clk);
    for (int i = 7; i >= 0; i--) begin
      serial_in <= tx[i];
      repeat (HALF) @(posedge ref_clk);
      rx[i] = sdo_w;
      drove = drove | !serial_out_oe_n;
      shift_clock <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
      shift_clock <= 1'b0;
    end
    repeat (HALF) @(posedge ref_clk);
    chip_enable_n <= 1'b1;
    serial_in <= ~serial_in;
    repeat (HALF) @(posedge ref_clk);
  endtask : xfer
endmodule : sfc_ctl_model

// *** sim/sfc_top_tb.sv ***
// Self-checking bench for the serial control block top.
// Assumes the controller model and the bound checker are compiled before it.
`timescale 1ns/10ps
module sfc_top_tb;
  localparam int CONV = 20;
  logic ref_clk, reset_n, por_n, pump_on_pin, reg_we, reg_re, dr;
  logic chip_enable_n, shift_clock, serial_in, serial_out, serial_out_oe_n, pump_run;
  logic attenuator_switch, junction_excitation_en, conversion_done_flag, conv_run;
  logic clock_replica_out, irq, input_select_bit_high, input_select_bit_mid;
  logic input_select_bit_low;
  logic [3:0] aux_inputs, aux_outputs;
  logic [23:0] conv_result;
  logic [7:0] reg_addr, b, d;
  logic [31:0] reg_wdata, reg_rdata, r;
  int n_fail = 0;
  int num_checks = 0;
  wire [2:0] sel = {input_select_bit_high, input_select_bit_mid, input_select_bit_low};
  sfc_top #(.CONV_CYCLES(CONV)) u_sfc_top (.ref_clk, .reset_n, .por_n, .chip_enable_n,
    .shift_clock, .serial_in, .serial_out, .serial_out_oe_n, .pump_on_pin, .pump_run,
    .aux_inputs, .aux_outputs, .input_select_bit_high, .input_select_bit_mid,
    .input_select_bit_low, .attenuator_switch, .junction_excitation_en,
    .conversion_done_flag, .conv_run, .conv_result, .clock_replica_out, .reg_addr,
    .reg_wdata, .reg_we, .reg_re, .reg_rdata, .irq);
  sfc_ctl_model u_sfc_ctl_model (.ref_clk, .chip_enable_n, .shift_clock, .serial_in,
    .serial_out, .serial_out_oe_n);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_we <= 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask : rd
  task automatic sx(input logic [7:0] t);
    u_sfc_ctl_model.xfer(t, d, dr);
  endtask : sx
  task automatic srd(input logic [7:0] c);
    sx(c);
    chk("cmd drive", 32'(dr), 32'h0);
    sx(8'h00);
    chk("read drive", 32'(dr), 32'h1);
  endtask : srd
  task automatic wait_done();
    int k;
    for (k = 0; k < 200 && conversion_done_flag !== 1'b1; k++) @(posedge ref_clk);
    if (k == 200) begin
      chk("done wait", 32'h0, 32'h1);
      stop_test();
    end
  endtask : wait_done
  initial begin
    {reset_n, por_n, pump_on_pin, reg_we, reg_re} = 5'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    aux_inputs = 4'ha;
    conv_result = 24'h5a3c96;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    rd(sfc_pkg::REG_CONFIG, r);
    chk("cfg reset", r, 32'h10);
    srd(8'h80);
    chk("status idle", 32'(d), 32'h0a);
    @(negedge ref_clk);
    chk("replica low", 32'(clock_replica_out), 32'h0);
    @(posedge ref_clk);
    #1 chk("replica", 32'(clock_replica_out), 32'h1);
    @(posedge ref_clk);
    pump_on_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("pump", 32'(pump_run), 32'h1);
    for (int c = 0; c < 8; c++) begin
      b = {3'h0, c[0], 1'b1, c[2:0]};
      sx(8'h20);
      sx(b);
      chk("select", 32'(sel), 32'(c));
      chk("atten", 32'(attenuator_switch), 32'(c < 4));
      chk("excite", 32'(junction_excitation_en), 32'(c[0]));
      srd(8'hc0);
      chk("cfg byte", 32'(d), 32'(b));
    end
    pump_on_pin <= 1'b0;
    wr(sfc_pkg::REG_CONFIG, 32'h02);
    chk("reg cfg", 32'({sel, attenuator_switch, junction_excitation_en}), 32'h08);
    sx(8'h40);
    sx(8'h05);
    chk("aux out", 32'(aux_outputs), 32'h5);
    rd(sfc_pkg::REG_AUX, r);
    chk("aux reg", r, 32'ha5);
    rd(8'hfc, r);
    chk("unmapped", r, 32'h0);
    wr(sfc_pkg::REG_AUX, 32'h3);
    chk("aux reg out", 32'(aux_outputs), 32'h3);
    wr(sfc_pkg::REG_IRQ_MASK, 32'h0);
    sx(8'h60);
    chk("busy", 32'({conv_run, conversion_done_flag}), 32'h2);
    wait_done();
    srd(8'h80);
    chk("status done", 32'(d), 32'h8a);
    sx(8'ha0);
    for (int k = 2; k >= 0; k--) begin
      sx(8'h00);
      chk("result", 32'(d), 32'(conv_result[k*8 +: 8]));
    end
    rd(sfc_pkg::REG_RESULT, r);
    chk("reg result", r, 32'h5a3c96);
    rd(sfc_pkg::REG_IRQ_STATUS, r);
    chk("ev done", r & 32'h1, 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    wr(sfc_pkg::REG_IRQ_MASK, 32'h7);
    chk("irq mask", 32'(irq), 32'h1);
    wr(sfc_pkg::REG_IRQ_STATUS, 32'h7);
    chk("irq clear", 32'(irq), 32'h0);
    sx(8'h20);
    wr(sfc_pkg::REG_CONTROL, 32'h1);
    rd(sfc_pkg::REG_CONTROL, r);
    chk("ctl busy", r, 32'h1);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("abort", 32'({conv_run, conversion_done_flag}), 32'h0);
    reset_n <= 1'b1;
    srd(8'h80);
    chk("cmd state", 32'(d), 32'h0a);
    rd(sfc_pkg::REG_CONFIG, r);
    chk("cfg kept", r, 32'h02);
    sx(8'he0);
    repeat (3) sx(8'h00);
    rd(sfc_pkg::REG_IRQ_STATUS, r);
    chk("three zero", r & 32'h6, 32'h4);
    sx(8'h00);
    rd(sfc_pkg::REG_IRQ_STATUS, r);
    chk("four zero", r & 32'h2, 32'h2);
    stop_test();
  end
endmodule : sfc_top_tb
